// ===== period_timer_pkg.sv
// constants shared by the gated period timer
package period_timer_pkg;
  // register offsets (word index == address on the plain port)
  localparam logic [3:0] OFS_CONTROL = 4'h0; // timer_control
  localparam logic [3:0] OFS_COUNT   = 4'h1; // count_value
  localparam logic [3:0] OFS_PERIOD  = 4'h2; // period register
  localparam logic [3:0] OFS_FLAGS   = 4'h3; // irq_flag_status_0
  localparam logic [3:0] OFS_ENABLE  = 4'h4; // irq_enable_ctl_0
  // control field positions
  localparam int BIT_ENABLE  = 15; // count_enable
  localparam int BIT_IDLE    = 13; // stop_in_idle
  localparam int BIT_GATE    = 6;  // gate_accumulate_enable
  localparam int BIT_PS_HI   = 5;  // prescale_select msb
  localparam int BIT_PS_LO   = 4;  // prescale_select lsb
  localparam int BIT_SYNC    = 2;  // external_sync_select
  localparam int BIT_SOURCE  = 1;  // clock_source_select
  // flag / enable bit positions
  localparam int BIT_MATCH   = 3;  // period_match_flag
  localparam int BIT_GATEEND = 4;  // gate falling edge flag
  // writable control bits
  localparam logic [15:0] CONTROL_MASK = 16'hA076;
  localparam logic [15:0] FLAG_MASK    = 16'h0018;
  // reset values
  localparam logic [15:0] RST_CONTROL = 16'h0000;
  localparam logic [15:0] RST_COUNT   = 16'h0000;
  localparam logic [15:0] RST_PERIOD  = 16'hFFFF;
  localparam logic [15:0] RST_ZERO    = 16'h0000;
  // prescaler terminal counts: divide-by minus one
  localparam logic [7:0] DIV1_LAST   = 8'h00;
  localparam logic [7:0] DIV8_LAST   = 8'h07;
  localparam logic [7:0] DIV64_LAST  = 8'h3F;
  localparam logic [7:0] DIV256_LAST = 8'hFF;
  localparam logic [1:0] PS_DIV1  = 2'h0;
  localparam logic [1:0] PS_DIV8  = 2'h1;
  localparam logic [1:0] PS_DIV64 = 2'h2;
endpackage : period_timer_pkg

// ===== gated_period_timer.sv
// gated 16-bit period timer with prescaler and interrupt flags
//
// Contract
// - 16-bit counter, normal or gated mode
// - gated: count half-rate core ticks while gate high
// - idle stops counting when stop_in_idle set
// - input is half-rate core or pin
// - prescale by 1, 8, 64 or 256
// - prescaler cleared: count write, disable, reset
// - disabled prescaler holds, no clear events
// - control write leaves count untouched
// - sleep counts only enabled, external, async
// - sleep counting wraps at period to zero
// - match sets flag, interrupt when enabled
// - gate falling edge also raises interrupt
// - flag and enable live in status/enable regs
`timescale 1ns/1ps
module gated_period_timer #(
  parameter int WIDTH = 16 // counter width
) (
  input  wire logic        i_core_clk,  // 250 MHz core clock
  input  wire logic        i_rst_n,     // async active-low reset
  input  wire logic [3:0]  i_addr,      // register index
  input  wire logic [15:0] i_wdata,     // write data
  input  wire logic        i_wr,        // write strobe
  input  wire logic        i_rd,        // read strobe
  input  wire logic        i_idle,      // processor idle level
  input  wire logic        i_sleep,     // processor sleep level
  input  wire logic        i_gate_clock_pin, // external clock / gate
  output logic      [15:0] o_rdata,     // read data, cycle after strobe
  output logic             o_irq,       // level interrupt
  output logic      [15:0] o_count      // live count value
);
  // elaboration check: only the 16-bit register layout is served
  if (WIDTH != 16)
  begin : g_width_check
    $error("gated_period_timer supports WIDTH 16 only");
  end

  // reset synchroniser
  logic rst_meta_reg;
  logic rst_sync_n;
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_n   <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_n   <= rst_meta_reg;
    end
  end

  logic [15:0] control_reg; // timer_control
  logic [15:0] count_reg;   // count_value
  logic [15:0] period_reg;  // period register
  logic [15:0] flags_reg;   // irq_flag_status_0
  logic [15:0] enable_reg;  // irq_enable_ctl_0
  logic [7:0]  presc_reg;   // prescaler count
  logic        half_reg;    // core/2 divider
  logic        pin_reg;     // previous pin level
  logic [7:0]  presc_last;  // prescaler terminal count

  // decoded control bits
  wire ctl_on     = control_reg[period_timer_pkg::BIT_ENABLE];
  wire ctl_idle   = control_reg[period_timer_pkg::BIT_IDLE];
  wire ctl_gate   = control_reg[period_timer_pkg::BIT_GATE];
  wire ctl_sync   = control_reg[period_timer_pkg::BIT_SYNC];
  wire ctl_source = control_reg[period_timer_pkg::BIT_SOURCE];
  wire [1:0] ctl_ps = {control_reg[period_timer_pkg::BIT_PS_HI],
                       control_reg[period_timer_pkg::BIT_PS_LO]};

  wire wr_control = i_wr && (i_addr == period_timer_pkg::OFS_CONTROL);
  wire wr_count   = i_wr && (i_addr == period_timer_pkg::OFS_COUNT);
  wire wr_period  = i_wr && (i_addr == period_timer_pkg::OFS_PERIOD);
  wire wr_flags   = i_wr && (i_addr == period_timer_pkg::OFS_FLAGS);
  wire wr_enable  = i_wr && (i_addr == period_timer_pkg::OFS_ENABLE);

  // pin edges; pin taken as synchronous to the core clock
  wire pin_rise = i_gate_clock_pin && !pin_reg;
  wire pin_fall = !i_gate_clock_pin && pin_reg;

  // sleep keeps only an enabled async external source alive
  wire sleep_ok = ctl_source && !ctl_sync;
  wire idle_hold = i_idle && ctl_idle;
  wire run = ctl_on && !idle_hold && (!i_sleep || sleep_ok);

  // raw input tick ahead of the prescaler
  logic in_tick;
  always_comb
  begin
    in_tick = 1'b0;
    if (ctl_source)
      in_tick = pin_rise;
    else if (ctl_gate)
      in_tick = half_reg && i_gate_clock_pin;
    else
      in_tick = half_reg;
  end

  // prescale code decode
  always_comb
  begin
    case (ctl_ps)
      period_timer_pkg::PS_DIV1:  presc_last = period_timer_pkg::DIV1_LAST;
      period_timer_pkg::PS_DIV8:  presc_last = period_timer_pkg::DIV8_LAST;
      period_timer_pkg::PS_DIV64: presc_last = period_timer_pkg::DIV64_LAST;
      default:                    presc_last = period_timer_pkg::DIV256_LAST;
    endcase
  end

  wire presc_tick = run && in_tick && (presc_reg >= presc_last);
  wire at_match   = (count_reg == period_reg);

  // core/2 instruction rate divider
  always_ff @(posedge i_core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      half_reg <= 1'b0;
    else
      half_reg <= !half_reg;
  end

  // pin history for edge detection
  always_ff @(posedge i_core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      pin_reg <= 1'b0;
    else
      pin_reg <= i_gate_clock_pin;
  end

  // prescaler: frozen while disabled, so clears only act when on
  always_ff @(posedge i_core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      presc_reg <= 8'h00;
    else if (ctl_on)
    begin
      if (wr_count || (wr_control && !i_wdata[period_timer_pkg::BIT_ENABLE]))
        presc_reg <= 8'h00;
      else if (run && in_tick)
        presc_reg <= presc_tick ? 8'h00 : presc_reg + 8'h01;
    end
    // disabled: hold, the prescaler clock is stopped
  end

  // control register; never touches the count
  always_ff @(posedge i_core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      control_reg <= period_timer_pkg::RST_CONTROL;
    else if (wr_control)
      control_reg <= i_wdata & period_timer_pkg::CONTROL_MASK;
  end

  // counter: write wins, then wrap after match, then increment
  always_ff @(posedge i_core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      count_reg <= period_timer_pkg::RST_COUNT;
    else if (wr_count)
      count_reg <= i_wdata;
    else if (presc_tick)
    begin
      if (at_match)
        count_reg <= period_timer_pkg::RST_ZERO;
      else
        count_reg <= count_reg + 16'h0001;
    end
  end

  // period register
  always_ff @(posedge i_core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      period_reg <= period_timer_pkg::RST_PERIOD;
    else if (wr_period)
      period_reg <= i_wdata;
  end

  // sticky flags, set wins over a write-one clear
  wire match_evt = presc_tick && at_match;
  wire gate_evt  = ctl_on && ctl_gate && !ctl_source && pin_fall;
  logic [15:0] flag_set;
  always_comb
  begin
    flag_set = 16'h0000;
    flag_set[period_timer_pkg::BIT_MATCH]   = match_evt;
    flag_set[period_timer_pkg::BIT_GATEEND] = gate_evt;
  end
  always_ff @(posedge i_core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      flags_reg <= period_timer_pkg::RST_ZERO;
    else
      flags_reg <= ((flags_reg & ~(wr_flags ? i_wdata : 16'h0000))
                    | flag_set) & period_timer_pkg::FLAG_MASK;
  end

  // interrupt enable mask
  always_ff @(posedge i_core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      enable_reg <= period_timer_pkg::RST_ZERO;
    else if (wr_enable)
      enable_reg <= i_wdata & period_timer_pkg::FLAG_MASK;
  end

  // interrupt level, registered
  always_ff @(posedge i_core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      o_irq <= 1'b0;
    else
      o_irq <= |(flags_reg & enable_reg);
  end

  // count mirror output
  always_ff @(posedge i_core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      o_count <= period_timer_pkg::RST_COUNT;
    else
      o_count <= count_reg;
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge i_core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      o_rdata <= 16'h0000;
    else if (i_rd)
    begin
      case (i_addr)
        period_timer_pkg::OFS_CONTROL: o_rdata <= control_reg;
        period_timer_pkg::OFS_COUNT:   o_rdata <= count_reg;
        period_timer_pkg::OFS_PERIOD:  o_rdata <= period_reg;
        period_timer_pkg::OFS_FLAGS:   o_rdata <= flags_reg;
        period_timer_pkg::OFS_ENABLE:  o_rdata <= enable_reg;
        default:                       o_rdata <= 16'h0000; // unmapped
      endcase
    end
    else
      o_rdata <= 16'h0000;
  end

  // checks
  a_match_sets_flag: assert property (@(posedge i_core_clk)
    disable iff (!rst_sync_n)
    match_evt |=> flags_reg[period_timer_pkg::BIT_MATCH])
    else $error("match did not set flag");

  a_wrap_to_zero: assert property (@(posedge i_core_clk)
    disable iff (!rst_sync_n)
    (match_evt && !wr_count) |=> (count_reg == 16'h0000))
    else $error("count did not wrap");

  a_control_keeps: assert property (@(posedge i_core_clk)
    disable iff (!rst_sync_n)
    (wr_control && !presc_tick) |=> $stable(count_reg))
    else $error("control write changed count");

  a_idle_stops: assert property (@(posedge i_core_clk)
    disable iff (!rst_sync_n)
    (idle_hold && !wr_count) |=> $stable(count_reg))
    else $error("count moved in idle");

  a_off_holds_presc: assert property (@(posedge i_core_clk)
    disable iff (!rst_sync_n)
    !ctl_on |=> $stable(presc_reg))
    else $error("prescaler moved while off");

  a_gate_low_hold: assert property (@(posedge i_core_clk)
    disable iff (!rst_sync_n)
    (ctl_gate && !ctl_source && !i_gate_clock_pin && !wr_count)
      |=> $stable(count_reg))
    else $error("gated count moved with gate low");

  a_sleep_sync_hold: assert property (@(posedge i_core_clk)
    disable iff (!rst_sync_n)
    (i_sleep && !sleep_ok && !wr_count) |=> $stable(count_reg))
    else $error("count moved in sleep");

  a_gate_fall_flag: assert property (@(posedge i_core_clk)
    disable iff (!rst_sync_n)
    gate_evt |=> flags_reg[period_timer_pkg::BIT_GATEEND])
    else $error("gate end flag missing");

  a_irq_follows: assert property (@(posedge i_core_clk)
    disable iff (!rst_sync_n)
    (flags_reg[period_timer_pkg::BIT_MATCH]
     && enable_reg[period_timer_pkg::BIT_MATCH]) |=> o_irq)
    else $error("irq not raised");

  a_count_write_clears: assert property (@(posedge i_core_clk)
    disable iff (!rst_sync_n)
    (wr_count && ctl_on) |=> (presc_reg == 8'h00))
    else $error("prescaler not cleared");

  a_off_write_clears: assert property (@(posedge i_core_clk)
    disable iff (!rst_sync_n)
    (wr_control && ctl_on && !i_wdata[period_timer_pkg::BIT_ENABLE])
      |=> (presc_reg == 8'h00))
    else $error("prescaler not cleared on disable");
endmodule : gated_period_timer

// ===== gate_pin_model.sv
// model of the source on the external clock / gate pin
`timescale 1ns/1ps
module gate_pin_model (
  input  wire logic i_clk,   // core clock
  input  wire logic i_rst_n, // active-low reset
  input  wire logic i_pulse, // run the pin as a clock
  input  wire logic i_level, // gate level when not pulsing
  output logic      o_pin    // drives the timer pin
);
  // pin moves only after an edge, as a synchronised source would
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_pin <= 1'b0; // quiet pin during reset
    else if (i_pulse)
      o_pin <= ~o_pin; // rising edge every 2 cycles
    else
      o_pin <= i_level; // gate held, clock stands still
  end
endmodule : gate_pin_model

// ===== gated_16bit_period_timer_tb.sv
// self-checking bench for the gated period timer
`timescale 1ns/1ps
module gated_16bit_period_timer_tb;
  localparam logic [3:0] A_CTL = period_timer_pkg::OFS_CONTROL;
  localparam logic [3:0] A_CNT = period_timer_pkg::OFS_COUNT;
  localparam logic [3:0] A_PER = period_timer_pkg::OFS_PERIOD;
  localparam logic [3:0] A_FLG = period_timer_pkg::OFS_FLAGS;
  localparam logic [3:0] A_ENA = period_timer_pkg::OFS_ENABLE;
  logic        clk = 1'b0;      // core clock
  logic        rst_n = 1'b0;    // active-low reset
  logic [3:0]  addr = 4'h0;     // register index
  logic [15:0] wdata = 16'h0000; // write data
  logic        wr = 1'b0;       // write strobe
  logic        rd = 1'b0;       // read strobe
  logic        idle = 1'b0;     // processor idle
  logic        sleep = 1'b0;    // processor sleep
  logic        pulse = 1'b0;    // pin model runs as clock
  logic        level = 1'b0;    // pin model gate level
  logic        pin;             // pin between model and timer
  logic [15:0] rdata;           // read data
  logic [15:0] count;           // live count
  logic        irq;             // interrupt level
  logic [15:0] v;               // read results
  logic [15:0] w;
  int          errors = 0;      // mismatches
  int          checks_done = 0; // comparisons
  int          dv [4] = '{1, 8, 64, 256}; // divide per code

  initial
  begin
    forever #2 clk = ~clk;
  end

  gate_pin_model i_gate_pin_model (.i_clk(clk), .i_rst_n(rst_n),
    .i_pulse(pulse), .i_level(level), .o_pin(pin));
  gated_period_timer i_gated_period_timer (.i_core_clk(clk),
    .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .i_idle(idle), .i_sleep(sleep),
    .i_gate_clock_pin(pin), .o_rdata(rdata), .o_irq(irq),
    .o_count(count));

  // compare and count; x never matches
  task automatic check(input logic [15:0] s, e, input string n);
    checks_done++;
    if (s !== e)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  // one-cycle write, then a free edge so strobes never collide
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wreg

  // data stands only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a, output logic [15:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask : rreg

  // bounded wait for the interrupt level
  task automatic wait_irq(input logic l);
    int k;
    for (k = 0; k < 3000 && irq !== l; k++)
      @(posedge clk);
    if (irq !== l)
    begin
      errors++;
      give_verdict();
    end
  endtask : wait_irq

  task automatic t_reset();
    rreg(A_CTL, v);
    check(v, 16'h0000, "control");
    rreg(A_PER, v);
    check(v, 16'hFFFF, "period");
    rreg(A_CNT, v);
    check(v, 16'h0000, "count");
    wreg(4'hF, 16'hFFFF);
    rreg(4'hF, v);
    check(v, 16'h0000, "unmapped");
    $display("reset test done");
  endtask : t_reset

  // every prescale code: about 4 increments in 8*div cycles
  task automatic t_prescale();
    for (int p = 0; p < 4; p++)
    begin
      wreg(A_CTL, 16'h8000 | 16'(p << 4));
      wreg(A_CNT, 16'h0000);
      repeat (8 * dv[p] - 2) @(posedge clk);
      rreg(A_CNT, v);
      check({15'h0000, v >= 3 && v <= 5}, 16'h0001, "scaled");
    end
    wreg(A_CTL, 16'h0000);
    $display("prescale test done");
  endtask : t_prescale

  task automatic t_ctrl();
    wreg(A_CNT, 16'h1234);
    wreg(A_CTL, 16'h0030);
    repeat (20) @(posedge clk);
    rreg(A_CNT, v);
    check(v, 16'h1234, "count kept");
    check(count, 16'h1234, "live count");
    $display("control write test done");
  endtask : t_ctrl

  // match with the interrupt masked, then unmasked, then cleared
  task automatic t_match();
    wreg(A_PER, 16'h0005);
    wreg(A_CNT, 16'h0000);
    wreg(A_CTL, 16'h8000);
    repeat (40) @(posedge clk);
    rreg(A_FLG, v);
    check(v, 16'h0008, "match flag");
    check({15'h0000, irq}, 16'h0000, "masked irq");
    rreg(A_CNT, v);
    check({15'h0000, v <= 5}, 16'h0001, "wrap");
    wreg(A_ENA, 16'h0008);
    wait_irq(1'b1);
    wreg(A_CTL, 16'h0000);
    wreg(A_FLG, 16'h0008);
    wait_irq(1'b0);
    rreg(A_FLG, v);
    check(v, 16'h0000, "cleared");
    $display("match test done");
  endtask : t_match

  task automatic t_idle();
    wreg(A_PER, 16'hFFFF);
    idle <= 1'b1;
    wreg(A_CTL, 16'hA000);
    rreg(A_CNT, v);
    repeat (20) @(posedge clk);
    rreg(A_CNT, w);
    check(w, v, "idle hold");
    idle <= 1'b0;
    repeat (20) @(posedge clk);
    rreg(A_CNT, w);
    check({15'h0000, w != v}, 16'h0001, "resume");
    wreg(A_CTL, 16'h8000);
    idle <= 1'b1;
    rreg(A_CNT, v);
    repeat (20) @(posedge clk);
    rreg(A_CNT, w);
    check({15'h0000, w != v}, 16'h0001, "idle run");
    idle <= 1'b0;
    $display("idle test done");
  endtask : t_idle

  // gate low holds, gate high counts half-rate core ticks, fall raises irq
  task automatic t_gate();
    wreg(A_ENA, 16'h0010);
    wreg(A_CTL, 16'h8040);
    wreg(A_CNT, 16'h0000);
    repeat (20) @(posedge clk);
    rreg(A_CNT, v);
    check(v, 16'h0000, "gate low");
    level <= 1'b1;
    repeat (20) @(posedge clk);
    level <= 1'b0;
    wait_irq(1'b1);
    rreg(A_CNT, v);
    check({15'h0000, v >= 9 && v <= 11}, 16'h0001, "gated");
    rreg(A_FLG, v);
    check(v, 16'h0010, "gate end");
    wreg(A_CTL, 16'h0000);
    wreg(A_FLG, 16'h0018);
    wreg(A_ENA, 16'h0000);
    $display("gate test done");
  endtask : t_gate

  task automatic t_sleep();
    wreg(A_PER, 16'h0003);
    wreg(A_CNT, 16'h0000);
    sleep <= 1'b1;
    wreg(A_CTL, 16'h8000);
    repeat (20) @(posedge clk);
    rreg(A_CNT, v);
    check(v, 16'h0000, "sleep internal");
    wreg(A_CTL, 16'h8002);
    pulse <= 1'b1;
    repeat (30) @(posedge clk);
    pulse <= 1'b0;
    rreg(A_FLG, v);
    check(v, 16'h0008, "sleep match");
    rreg(A_CNT, v);
    check({15'h0000, v <= 3}, 16'h0001, "sleep wrap");
    wreg(A_CTL, 16'h8006);
    wreg(A_CNT, 16'h0000);
    pulse <= 1'b1;
    repeat (20) @(posedge clk);
    pulse <= 1'b0;
    rreg(A_CNT, v);
    check(v, 16'h0000, "sleep sync");
    sleep <= 1'b0;
    $display("sleep test done");
  endtask : t_sleep

  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_prescale();
    t_ctrl();
    t_match();
    t_idle();
    t_gate();
    t_sleep();
    give_verdict();
  end
endmodule : gated_16bit_period_timer_tb
